// ---- common/pmsd_defs.svh ----
// Operation
// - Long power-key press or long joint gpio A+B assertion starts interruptible shutdown.
// - Shutdown pin falling edge or host halt request forces non-interruptible shutdown.
// - Watchdog miss, low system supply or over-temperature force non-interruptible shutdown.
// - Kill line falling edge always forces fast emergency shutdown.
// - Per-trigger style picks reverse sequencing or immediate jump to reset mode.
// - Shutdown source logged as key or pin flag; host clears by writing one.
// - User style one turns a long user press into a full power-on reset.
// - Aborted configuration read enters reset mode without logging any flag.
// - Shutdown asserts host reset first, then powers system down to slot zero.
// - Reset entry clears events; reset exit reloads configuration, keeps self power-up on fault.
// - Fault record and non-reloaded registers survive leaving reset mode.
// - Host reset low after cold start; optionally before host-requested power-down.
// - Request triggers self-clear; kill and shutdown pins must release before leaving reset.
// - Reset mode lasts at least the selected minimum hold duration.
// - Long press sets key flag and interrupt; shutdown after 1 s unless host clears.
// - Leaving reset waits for a good system supply above upper threshold.
// - Armed clock mode on power-down enters clock-keeping mode at sequencer slot zero.
// - Armed: supply fault, fault clock mode or low reference enter clock-keeping mode.
// - Clock-keeping ends on key, charger, tick, alarm or reference rise; core regulator on.
// - Unarmed, clock-keeping entry conditions other than supply fault lead to shipping mode with reduced wake set.
// - Download mode drives supply fault low until download done; second one on system enable request.
// - Download mode makes gpio A/B the fast port, gpio C the fault output, locked.
`ifndef PMSD_DEFS_SVH
`define PMSD_DEFS_SVH
`define PMSD_CLK_HZ 25000000
`define PMSD_LONG_MS 5000
`define PMSD_KEY_WAIT_MS 1000
`define PMSD_HOLD_STEP_MS 10
`define PMSD_LONG_CYC (`PMSD_LONG_MS * (`PMSD_CLK_HZ / 1000))
`define PMSD_WAIT_CYC (`PMSD_KEY_WAIT_MS * (`PMSD_CLK_HZ / 1000))
`define PMSD_STEP_CYC (`PMSD_HOLD_STEP_MS * (`PMSD_CLK_HZ / 1000))
`define PMSD_CNT_W 28
`define PMSD_NPIN 7
`define PMSD_PIN_KEY 0
`define PMSD_PIN_GPA 1
`define PMSD_PIN_GPB 2
`define PMSD_PIN_SHDN 3
`define PMSD_PIN_KILL 4
`define PMSD_PIN_CHG 5
`define PMSD_PIN_DLM 6
`define PMSD_PIN_IDLE 7'h19
`endif

// ---- common/pmsd_pkg.sv ----
package pmsd_pkg;
  typedef enum logic [3:0] {
    ST_START, ST_DL, ST_RUN, ST_KEYWAIT, ST_SD_HRST, ST_SD_SEQ, ST_RESET, ST_RTC, ST_DELIV
  } pmsd_state_t;
  typedef enum logic [1:0] {DEST_RESET, DEST_RTC, DEST_DELIV} pmsd_dest_t;
endpackage : pmsd_pkg

// ---- common/pmsd_pin_if.sv ----
`timescale 1ns/1ps
`include "pmsd_defs.svh"
interface pmsd_pin_if;
  logic [`PMSD_NPIN-1:0] raw;
  logic [`PMSD_NPIN-1:0] sync;
  logic [`PMSD_NPIN-1:0] fall;
  modport src (input raw, output sync, output fall);
  modport dst (output raw, input sync, input fall);
endinterface : pmsd_pin_if

// ---- design/pmsd_pins.sv ----
`timescale 1ns/1ps
`include "pmsd_defs.svh"
module pmsd_pins (
  input wire logic mclk,
  input wire logic sys_rst,
  pmsd_pin_if.src pins
);
  logic [`PMSD_NPIN-1:0] s1_q;
  logic [`PMSD_NPIN-1:0] s1_d;
  logic [`PMSD_NPIN-1:0] s2_q;
  logic [`PMSD_NPIN-1:0] s2_d;
  logic [`PMSD_NPIN-1:0] s3_q;
  logic [`PMSD_NPIN-1:0] s3_d;

  always_comb
  begin
    s1_d = pins.raw;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Edges are taken from the second stage on, never the first
  // Stages keep sampling through reset so pin levels are valid as it lifts;
  // the edge stage tracks the second one then, so no edge comes out of reset
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s2_d;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign pins.sync = s2_q;
  assign pins.fall = s3_q & ~s2_q;
endmodule : pmsd_pins

// ---- design/pmsd_top.sv ----
`timescale 1ns/1ps
`include "pmsd_defs.svh"
module pmsd_top #(
  parameter int unsigned LONG_CYC = `PMSD_LONG_CYC,
  parameter int unsigned WAIT_CYC = `PMSD_WAIT_CYC,
  parameter int unsigned STEP_CYC = `PMSD_STEP_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic power_key_n,
  input wire logic gpio_pin_a,
  input wire logic gpio_pin_b,
  input wire logic shutdown_pin_n,
  input wire logic fault_line_kill_n,
  input wire logic charger_wake,
  input wire logic dl_mode_pin,
  input wire logic wdg_expired,
  input wire logic supply_low,
  input wire logic over_temp,
  input wire logic supply_good,
  input wire logic ref_low,
  input wire logic ref_high,
  input wire logic rtc_tick,
  input wire logic rtc_alarm,
  input wire logic otp_abort,
  input wire logic vdd_start_fault,
  input wire logic seq_at_zero,
  input wire logic seq_sys_up,
  input wire logic host_pd_req,
  input wire logic sys_en_req,
  input wire logic download_done,
  input wire logic internal_sd_style,
  input wire logic host_sd_style,
  input wire logic user_sd_style,
  input wire logic host_reset_timing_sel,
  input wire logic [3:0] min_hold_duration,
  input wire logic clock_keep_arm,
  input wire logic clock_mode_on_powerdown,
  input wire logic clock_mode_on_fault,
  input wire logic halt_request_bit,
  input wire logic clr_key_flag,
  input wire logic clr_pin_flag,
  output logic host_reset_n,
  output logic interrupt_out_n,
  output logic supply_fault_out_n,
  output logic gpio_pin_c,
  output logic key_shutdown_flag,
  output logic pin_shutdown_flag,
  output logic core_regulator_en,
  output logic seq_down_req,
  output logic seq_fast_off,
  output logic por_req,
  output logic events_clear,
  output logic otp_reload,
  output logic keep_self_power_up,
  output logic two_wire_sel,
  output logic cfg_lock,
  output logic [3:0] mode_state
);
  localparam int W = `PMSD_CNT_W;

  pmsd_pin_if pins ();

  assign pins.raw = {dl_mode_pin, charger_wake, fault_line_kill_n, shutdown_pin_n,
                     gpio_pin_b, gpio_pin_a, power_key_n};

  pmsd_pins u_pins (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pins(pins)
  );

  logic key_s;
  logic pair_s;
  logic chg_s;
  logic dl_s;
  logic shdn_fall;
  logic kill_fall;
  logic pins_free;
  logic [W-1:0] hold_lim;

  assign key_s = ~pins.sync[`PMSD_PIN_KEY];
  assign pair_s = pins.sync[`PMSD_PIN_GPA] & pins.sync[`PMSD_PIN_GPB];
  assign chg_s = pins.sync[`PMSD_PIN_CHG];
  assign dl_s = pins.sync[`PMSD_PIN_DLM];
  assign shdn_fall = pins.fall[`PMSD_PIN_SHDN];
  assign kill_fall = pins.fall[`PMSD_PIN_KILL];
  assign pins_free = pins.sync[`PMSD_PIN_SHDN] & pins.sync[`PMSD_PIN_KILL];
  assign hold_lim = W'(min_hold_duration) * W'(STEP_CYC);

  // Long press detector, fires once per press
  logic [W-1:0] press_q;
  logic [W-1:0] press_d;
  logic long_q;
  logic long_d;

  always_comb
  begin
    press_d = press_q;
    long_d = 1'b0;
    if (!(key_s || pair_s))
      press_d = '0;
    else if (press_q < W'(LONG_CYC))
    begin
      press_d = press_q + W'(1);
      long_d = (press_q == W'(LONG_CYC - 1));
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      press_q <= '0;
      long_q <= 1'b0;
    end
    else
    begin
      press_q <= press_d;
      long_q <= long_d;
    end
  end

  logic halt_q;
  logic halt_d;

  // Non-interruptible trigger decode, in priority order
  logic f_go;
  logic f_fast;
  logic f_pin;
  logic f_halt;
  pmsd_pkg::pmsd_dest_t f_dest;

  always_comb
  begin
    f_go = 1'b1;
    f_fast = 1'b1;
    f_pin = 1'b0;
    f_halt = 1'b0;
    f_dest = pmsd_pkg::DEST_RESET;
    if (kill_fall)
      f_fast = 1'b1;
    else if (otp_abort)
      f_fast = 1'b1;
    else if (shdn_fall || halt_q)
    begin
      f_pin = shdn_fall;
      f_halt = 1'b1;
      f_fast = host_sd_style;
    end
    else if (wdg_expired || over_temp)
      f_fast = internal_sd_style;
    // supply fault parks in clock mode when armed
    else if (supply_low)
    begin
      f_fast = internal_sd_style;
      f_dest = clock_keep_arm ? pmsd_pkg::DEST_RTC : pmsd_pkg::DEST_RESET;
    end
    // unarmed entry goes to shipping mode
    else if (ref_low || clock_mode_on_fault)
    begin
      f_fast = internal_sd_style;
      f_dest = clock_keep_arm ? pmsd_pkg::DEST_RTC : pmsd_pkg::DEST_DELIV;
    end
    else
      f_go = 1'b0;
  end

  pmsd_pkg::pmsd_state_t state_q;
  pmsd_pkg::pmsd_state_t state_d;
  pmsd_pkg::pmsd_dest_t dest_q;
  pmsd_pkg::pmsd_dest_t dest_d;
  logic fast_q;
  logic fast_d;
  logic dl2_q;
  logic dl2_d;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic key_set;
  logic pin_set;
  logic halt_clr;
  logic por_d;
  logic evc_d;
  logic otp_d;
  logic keep_d;

  always_comb
  begin
    state_d = state_q;
    dest_d = dest_q;
    fast_d = fast_q;
    dl2_d = dl2_q;
    cnt_d = cnt_q;
    key_set = 1'b0;
    pin_set = 1'b0;
    halt_clr = 1'b0;
    por_d = 1'b0;
    evc_d = 1'b0;
    otp_d = 1'b0;
    keep_d = keep_self_power_up;
    case (state_q)
      pmsd_pkg::ST_START:
      begin
        if (supply_good)
          state_d = dl_s ? pmsd_pkg::ST_DL : pmsd_pkg::ST_RUN;
        dl2_d = 1'b0;
      end
      pmsd_pkg::ST_DL:
      begin
        if (download_done)
          state_d = pmsd_pkg::ST_RUN;
      end
      pmsd_pkg::ST_RUN, pmsd_pkg::ST_KEYWAIT:
      begin
        cnt_d = cnt_q + W'(1);
        if (f_go)
        begin
          state_d = pmsd_pkg::ST_SD_HRST;
          fast_d = f_fast;
          dest_d = f_dest;
          pin_set = f_pin;
          halt_clr = f_halt;
        end
        else if (state_q == pmsd_pkg::ST_KEYWAIT)
        begin
          // host cancel or 1 s timeout
          if (clr_key_flag)
            state_d = pmsd_pkg::ST_RUN;
          else if (cnt_q == W'(WAIT_CYC - 1))
          begin
            state_d = pmsd_pkg::ST_SD_HRST;
            dest_d = pmsd_pkg::DEST_RESET;
            fast_d = user_sd_style;
            por_d = user_sd_style;
          end
        end
        else if (seq_at_zero && host_pd_req && clock_mode_on_powerdown)
          state_d = clock_keep_arm ? pmsd_pkg::ST_RTC : pmsd_pkg::ST_DELIV;
        else if (long_q && !dl_s)
        begin
          key_set = 1'b1;
          cnt_d = '0;
          state_d = pmsd_pkg::ST_KEYWAIT;
        end
        else if (dl_s && sys_en_req && !dl2_q)
        begin
          dl2_d = 1'b1;
          state_d = pmsd_pkg::ST_DL;
        end
      end
      pmsd_pkg::ST_SD_HRST:
      begin
        state_d = pmsd_pkg::ST_SD_SEQ;
        halt_clr = 1'b1;
      end
      pmsd_pkg::ST_SD_SEQ:
      begin
        if (fast_q || seq_at_zero)
        begin
          cnt_d = '0;
          case (dest_q)
            pmsd_pkg::DEST_RTC: state_d = pmsd_pkg::ST_RTC;
            pmsd_pkg::DEST_DELIV: state_d = pmsd_pkg::ST_DELIV;
            default:
            begin
              state_d = pmsd_pkg::ST_RESET;
              evc_d = 1'b1;
            end
          endcase
        end
      end
      pmsd_pkg::ST_RESET:
      begin
        if (cnt_q < hold_lim)
          cnt_d = cnt_q + W'(1);
        // minimum hold, pins released, supply good
        else if (pins_free && supply_good)
        begin
          state_d = pmsd_pkg::ST_START;
          // reload, self power-up kept after start fault
          otp_d = 1'b1;
          keep_d = vdd_start_fault;
        end
      end
      pmsd_pkg::ST_RTC:
      begin
        if (key_s || chg_s || rtc_tick || rtc_alarm || ref_high)
        begin
          state_d = pmsd_pkg::ST_START;
          otp_d = 1'b1;
        end
      end
      pmsd_pkg::ST_DELIV:
      begin
        if (key_s || chg_s || ref_high)
        begin
          state_d = pmsd_pkg::ST_START;
          otp_d = 1'b1;
        end
      end
      default: state_d = pmsd_pkg::ST_START;
    endcase
  end

  // set wins over a host clear; never touched by reset exit
  logic key_d;
  logic pin_d;
  assign key_d = key_set | (key_shutdown_flag & ~clr_key_flag);
  assign pin_d = pin_set | (pin_shutdown_flag & ~clr_pin_flag);
  assign halt_d = halt_request_bit | (halt_q & ~halt_clr);

  // Outputs follow the next state so they line up with state_q
  logic run_d;
  logic hrst_d;
  logic sf_n_d;
  assign run_d = (state_d == pmsd_pkg::ST_RUN) || (state_d == pmsd_pkg::ST_KEYWAIT);
  // low from cold start, optionally ahead of host power-down
  assign hrst_d = run_d && seq_sys_up && !(host_reset_timing_sel && host_pd_req);
  assign sf_n_d = dl_s ? (state_d != pmsd_pkg::ST_DL) : ~supply_low;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_q <= pmsd_pkg::ST_START;
      dest_q <= pmsd_pkg::DEST_RESET;
      fast_q <= 1'b0;
      dl2_q <= 1'b0;
      halt_q <= 1'b0;
      cnt_q <= '0;
      key_shutdown_flag <= 1'b0;
      pin_shutdown_flag <= 1'b0;
      host_reset_n <= 1'b0;
      interrupt_out_n <= 1'b1;
      supply_fault_out_n <= 1'b1;
      gpio_pin_c <= 1'b0;
      core_regulator_en <= 1'b1;
      seq_down_req <= 1'b0;
      seq_fast_off <= 1'b0;
      por_req <= 1'b0;
      events_clear <= 1'b0;
      otp_reload <= 1'b0;
      keep_self_power_up <= 1'b0;
      two_wire_sel <= 1'b0;
      cfg_lock <= 1'b0;
      mode_state <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      dest_q <= dest_d;
      fast_q <= fast_d;
      dl2_q <= dl2_d;
      halt_q <= halt_d;
      cnt_q <= cnt_d;
      key_shutdown_flag <= key_d;
      pin_shutdown_flag <= pin_d;
      host_reset_n <= hrst_d;
      interrupt_out_n <= ~key_d;
      supply_fault_out_n <= sf_n_d;
      // gpio C carries the fault output in download mode
      gpio_pin_c <= dl_s & sf_n_d;
      // core regulator off only in low-power modes
      core_regulator_en <= !(state_d == pmsd_pkg::ST_RTC || state_d == pmsd_pkg::ST_DELIV);
      seq_down_req <= (state_d == pmsd_pkg::ST_SD_SEQ) && !fast_d;
      seq_fast_off <= (state_d == pmsd_pkg::ST_SD_SEQ) && fast_d;
      por_req <= por_d;
      events_clear <= evc_d;
      otp_reload <= otp_d;
      keep_self_power_up <= keep_d;
      two_wire_sel <= dl_s;
      cfg_lock <= dl_s;
      mode_state <= state_d;
    end
  end

  AST_KILL_GO:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_RUN && kill_fall) |=>
    (state_q == pmsd_pkg::ST_SD_HRST && fast_q && dest_q == pmsd_pkg::DEST_RESET))
  else $error("kill edge did not start fast shutdown");

  AST_SHDN_LOG:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_RUN && shdn_fall && !kill_fall && !otp_abort) |=>
    (pin_shutdown_flag && state_q == pmsd_pkg::ST_SD_HRST))
  else $error("shutdown pin edge not logged or not acted on");

  AST_HRST_SEQ:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_SD_HRST) |=> (state_q == pmsd_pkg::ST_SD_SEQ && !host_reset_n))
  else $error("host reset not held during power-down");

  AST_KEY_ENTRY:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_KEYWAIT && $changed(state_q)) |->
    (key_shutdown_flag && !interrupt_out_n && cnt_q == '0))
  else $error("long press did not flag and interrupt");

  AST_KEY_CANCEL:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_KEYWAIT && clr_key_flag && !f_go) |=>
    (state_q == pmsd_pkg::ST_RUN && !key_shutdown_flag))
  else $error("host clear did not cancel key shutdown");

  AST_ABORT_QUIET:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_RUN && otp_abort && !kill_fall && !pin_shutdown_flag &&
     !key_shutdown_flag) |=> (!pin_shutdown_flag && !key_shutdown_flag && fast_q))
  else $error("aborted read logged a fault flag");

  AST_EV_CLEAR:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_RESET && $changed(state_q)) |-> events_clear)
  else $error("events not cleared on reset entry");

  AST_PIN_HOLD:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_RESET && !pins_free) |=> (state_q == pmsd_pkg::ST_RESET))
  else $error("left reset mode with a trigger pin still low");

  AST_CORE_OFF:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_RTC || state_q == pmsd_pkg::ST_DELIV) |-> !core_regulator_en)
  else $error("core regulator on in a low-power mode");

  AST_DL_REQ:
  assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == pmsd_pkg::ST_DL && dl_s) |-> (!supply_fault_out_n && !gpio_pin_c))
  else $error("download request not driven");
endmodule : pmsd_top

// ---- sim/pmsd_host_model.sv ----
`timescale 1ns/1ps
module pmsd_host_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic key_shutdown_flag,
  input wire logic pin_shutdown_flag,
  input wire logic cancel_en,
  input wire logic ack_pin,
  input wire logic [1:0] pin_req,
  output logic clr_key_flag,
  output logic clr_pin_flag,
  output logic shutdown_pin_n,
  output logic fault_line_kill_n
);
  logic [3:0] low_q;
  initial {clr_key_flag, clr_pin_flag, shutdown_pin_n, fault_line_kill_n} = 4'h3;
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      {clr_key_flag, clr_pin_flag, shutdown_pin_n, fault_line_kill_n} <= 4'h3;
      low_q <= 4'h0;
    end
    else
    begin
      // key flag write-one
      // One write per sighting: the flag needs a clock to drop, so no double write
      clr_key_flag <= cancel_en & key_shutdown_flag & ~clr_key_flag;
      clr_pin_flag <= ack_pin & pin_shutdown_flag & ~clr_pin_flag;
      if (pin_req != 2'h0)
      begin
        shutdown_pin_n <= ~pin_req[0];
        fault_line_kill_n <= ~pin_req[1];
        low_q <= 4'h8;
      end
      else if (low_q == 4'h1)
      begin
        shutdown_pin_n <= 1'h1;
        fault_line_kill_n <= 1'h1;
        low_q <= 4'h0;
      end
      else if (low_q != 4'h0)
        low_q <= low_q - 4'h1;
    end
  end
endmodule : pmsd_host_model

// ---- sim/pmic_shutdown_lowpower_modes_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module pmic_shutdown_lowpower_modes_tb_top;
  logic mclk, sys_rst, power_key_n, gpio_pin_a, gpio_pin_b, charger_wake, dl_mode_pin;
  logic wdg_expired, supply_low, over_temp, supply_good, ref_low, ref_high, rtc_tick;
  logic rtc_alarm, otp_abort, vdd_start_fault, seq_at_zero, seq_sys_up, host_pd_req;
  logic sys_en_req, download_done, internal_sd_style, host_sd_style, user_sd_style;
  logic host_reset_timing_sel, clock_keep_arm, clock_mode_on_powerdown, clock_mode_on_fault;
  logic halt_request_bit, clr_key_flag, clr_pin_flag, shutdown_pin_n, fault_line_kill_n;
  logic host_reset_n, interrupt_out_n, supply_fault_out_n, gpio_pin_c, key_shutdown_flag;
  logic pin_shutdown_flag, core_regulator_en, seq_down_req, seq_fast_off, por_req;
  logic events_clear, otp_reload, keep_self_power_up, two_wire_sel, cfg_lock;
  logic cancel_en, ack_pin, at_zero_force;
  logic [1:0] pin_req;
  logic [3:0] min_hold_duration, mode_state;
  int fails = 0, num_checks = 0, cyc = 0, n_por = 0, n_otp = 0, k;
  pmsd_top #(.LONG_CYC(20), .WAIT_CYC(16), .STEP_CYC(4)) dut (
    .mclk, .sys_rst, .power_key_n, .gpio_pin_a, .gpio_pin_b, .shutdown_pin_n,
    .fault_line_kill_n, .charger_wake, .dl_mode_pin, .wdg_expired, .supply_low, .over_temp,
    .supply_good, .ref_low, .ref_high, .rtc_tick, .rtc_alarm, .otp_abort, .vdd_start_fault,
    .seq_at_zero, .seq_sys_up, .host_pd_req, .sys_en_req, .download_done, .internal_sd_style,
    .host_sd_style, .user_sd_style, .host_reset_timing_sel, .min_hold_duration,
    .clock_keep_arm, .clock_mode_on_powerdown, .clock_mode_on_fault, .halt_request_bit,
    .clr_key_flag, .clr_pin_flag, .host_reset_n, .interrupt_out_n, .supply_fault_out_n,
    .gpio_pin_c, .key_shutdown_flag, .pin_shutdown_flag, .core_regulator_en, .seq_down_req,
    .seq_fast_off, .por_req, .events_clear, .otp_reload, .keep_self_power_up, .two_wire_sel,
    .cfg_lock, .mode_state);
  pmsd_host_model host (.mclk, .sys_rst, .key_shutdown_flag, .pin_shutdown_flag, .cancel_en,
    .ack_pin, .pin_req, .clr_key_flag, .clr_pin_flag, .shutdown_pin_n, .fault_line_kill_n);
  task automatic close_out;
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Sequencer stand-in reaches slot zero one clock after a power-down request
  always @(posedge mclk)
  begin
    cyc++;
    if (por_req === 1'h1) n_por++;
    if (otp_reload === 1'h1) n_otp++;
    seq_at_zero <= seq_down_req | at_zero_force;
    if (cyc == 20000)
    begin
      fails++;
      close_out;
    end
  end
  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  task automatic wait_mode(input logic [3:0] m);
    for (int i = 0; i < 300 && mode_state !== m; i++) @(negedge mclk);
    `CHK("mode_state", m, mode_state)
  endtask : wait_mode
  task automatic do_reset;
    @(posedge mclk) sys_rst <= 1'h1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
  endtask : do_reset
  task automatic sd_path(input logic fast, input logic lowsup);
    int cnt;
    wait_mode(pmsd_pkg::ST_SD_HRST);
    `CHK("host_reset_n", 1'h0, host_reset_n)
    wait_mode(pmsd_pkg::ST_SD_SEQ);
    `CHK("seq_fast_off", fast, seq_fast_off)
    `CHK("seq_down_req", ~fast, seq_down_req)
    wait_mode(pmsd_pkg::ST_RESET);
    `CHK("events_clear", 1'h1, events_clear)
    n_otp = 0;
    cnt = 1;
    if (lowsup)
    begin
      @(posedge mclk) supply_good <= 1'h0;
      repeat (40) @(negedge mclk);
      `CHK("mode_state", pmsd_pkg::ST_RESET, mode_state)
      @(posedge mclk) supply_good <= 1'h1;
      cnt = 42;
    end
    while (mode_state === pmsd_pkg::ST_RESET && cnt < 300)
    begin
      @(negedge mclk);
      cnt++;
    end
    `CHK("hold_long_enough", 1'h1, cnt > 12)
    wait_mode(pmsd_pkg::ST_RUN);
    `CHK("otp_reload", 1, n_otp)
  endtask : sd_path
  task automatic t_cold;
    @(negedge mclk);
    `CHK("host_reset_n", 1'h0, host_reset_n)
    wait_mode(pmsd_pkg::ST_RUN);
    @(negedge mclk);
    `CHK("host_reset_n", 1'h1, host_reset_n)
  endtask : t_cold
  task automatic t_pins;
    @(posedge mclk) pin_req <= 2'h2;
    @(posedge mclk) pin_req <= 2'h0;
    sd_path(1'h1, 1'h0);
    @(posedge mclk) pin_req <= 2'h1;
    @(posedge mclk) pin_req <= 2'h0;
    sd_path(1'h0, 1'h1);
    `CHK("pin_shutdown_flag", 1'h1, pin_shutdown_flag)
    @(posedge mclk) ack_pin <= 1'h1;
    repeat (4) @(negedge mclk);
    `CHK("pin_shutdown_flag", 1'h0, pin_shutdown_flag)
    @(posedge mclk) ack_pin <= 1'h0;
  endtask : t_pins
  task automatic t_host_err;
    @(posedge mclk) {host_sd_style, internal_sd_style} <= 2'h3;
    halt_request_bit <= 1'h1;
    vdd_start_fault <= 1'h1;
    @(posedge mclk) halt_request_bit <= 1'h0;
    sd_path(1'h1, 1'h0);
    `CHK("keep_self_power_up", 1'h1, keep_self_power_up)
    @(posedge mclk) vdd_start_fault <= 1'h0;
    repeat (30) @(negedge mclk);
    `CHK("mode_state", pmsd_pkg::ST_RUN, mode_state)
    for (k = 0; k < 4; k++)
    begin
      @(posedge mclk) {otp_abort, supply_low, over_temp, wdg_expired} <= 4'h1 << k;
      @(posedge mclk) {otp_abort, supply_low, over_temp, wdg_expired} <= 4'h0;
      sd_path(1'h1, 1'h0);
      `CHK("no_flag", 2'h0, {key_shutdown_flag, pin_shutdown_flag})
    end
    `CHK("keep_self_power_up", 1'h0, keep_self_power_up)
  endtask : t_host_err
  task automatic t_user;
    @(posedge mclk) power_key_n <= 1'h0;
    wait_mode(pmsd_pkg::ST_KEYWAIT);
    `CHK("key_shutdown_flag", 1'h1, key_shutdown_flag)
    `CHK("interrupt_out_n", 1'h0, interrupt_out_n)
    @(posedge mclk) power_key_n <= 1'h1;
    cancel_en <= 1'h1;
    wait_mode(pmsd_pkg::ST_RUN);
    repeat (30) @(negedge mclk);
    `CHK("mode_state", pmsd_pkg::ST_RUN, mode_state)
    `CHK("key_shutdown_flag", 1'h0, key_shutdown_flag)
    @(posedge mclk) {cancel_en, user_sd_style, gpio_pin_a, gpio_pin_b} <= 4'h7;
    wait_mode(pmsd_pkg::ST_KEYWAIT);
    @(posedge mclk) {gpio_pin_a, gpio_pin_b} <= 2'h0;
    n_por = 0;
    sd_path(1'h1, 1'h0);
    `CHK("por_req", 1, n_por)
  endtask : t_user
  task automatic t_low_power;
    @(posedge mclk) clock_keep_arm <= 1'h1;
    for (k = 0; k < 5; k++)
    begin
      @(posedge mclk) {supply_low, clock_mode_on_fault, ref_low} <= 3'h1 << (k % 3);
      @(posedge mclk) {supply_low, clock_mode_on_fault, ref_low} <= 3'h0;
      wait_mode(pmsd_pkg::ST_RTC);
      `CHK("core_regulator_en", 1'h0, core_regulator_en)
      @(posedge mclk) {power_key_n, ref_high, rtc_alarm, rtc_tick, charger_wake} <=
        5'h10 ^ (5'h1 << k);
      @(posedge mclk) {power_key_n, ref_high, rtc_alarm, rtc_tick, charger_wake} <= 5'h10;
      wait_mode(pmsd_pkg::ST_RUN);
      `CHK("core_regulator_en", 1'h1, core_regulator_en)
    end
    @(posedge mclk) {host_reset_timing_sel, clock_mode_on_powerdown, host_pd_req} <= 3'h7;
    repeat (3) @(negedge mclk);
    `CHK("host_reset_n", 1'h0, host_reset_n)
    @(posedge mclk) at_zero_force <= 1'h1;
    wait_mode(pmsd_pkg::ST_RTC);
    @(posedge mclk) {at_zero_force, host_pd_req, clock_keep_arm} <= 3'h0;
    charger_wake <= 1'h1;
    @(posedge mclk) charger_wake <= 1'h0;
    wait_mode(pmsd_pkg::ST_RUN);
    for (k = 0; k < 2; k++)
    begin
      @(posedge mclk) {clock_mode_on_fault, ref_low} <= 2'h1 << k;
      @(posedge mclk) {clock_mode_on_fault, ref_low} <= 2'h0;
      wait_mode(pmsd_pkg::ST_DELIV);
      @(posedge mclk) rtc_tick <= 1'h1;
      @(posedge mclk) rtc_tick <= 1'h0;
      repeat (10) @(negedge mclk);
      `CHK("mode_state", pmsd_pkg::ST_DELIV, mode_state)
      @(posedge mclk) charger_wake <= 1'h1;
      @(posedge mclk) charger_wake <= 1'h0;
      wait_mode(pmsd_pkg::ST_RUN);
    end
  endtask : t_low_power
  task automatic t_download;
    @(posedge mclk) dl_mode_pin <= 1'h1;
    do_reset;
    for (k = 0; k < 2; k++)
    begin
      wait_mode(pmsd_pkg::ST_DL);
      `CHK("supply_fault_out_n", 1'h0, supply_fault_out_n)
      `CHK("gpio_pin_c", 1'h0, gpio_pin_c)
      `CHK("port_and_lock", 2'h3, {two_wire_sel, cfg_lock})
      @(posedge mclk) download_done <= 1'h1;
      @(posedge mclk) download_done <= 1'h0;
      wait_mode(pmsd_pkg::ST_RUN);
      `CHK("gpio_pin_c", 1'h1, gpio_pin_c)
      @(posedge mclk) {gpio_pin_a, gpio_pin_b, sys_en_req} <= 3'h7;
    end
    repeat (60) @(negedge mclk);
    `CHK("mode_state", pmsd_pkg::ST_RUN, mode_state)
  endtask : t_download
  initial
  begin
    {gpio_pin_a, gpio_pin_b, charger_wake, dl_mode_pin, wdg_expired, supply_low} = '0;
    {over_temp, ref_low, ref_high, rtc_tick, rtc_alarm, otp_abort, vdd_start_fault} = '0;
    {seq_at_zero, host_pd_req, sys_en_req, download_done, internal_sd_style} = '0;
    {host_sd_style, user_sd_style, host_reset_timing_sel, clock_keep_arm} = '0;
    {clock_mode_on_powerdown, clock_mode_on_fault, halt_request_bit} = '0;
    {cancel_en, ack_pin, at_zero_force, pin_req} = '0;
    {sys_rst, power_key_n, supply_good, seq_sys_up} = 4'hf;
    min_hold_duration = 4'h3;
    do_reset;
    t_cold;
    t_pins;
    t_host_err;
    t_user;
    t_low_power;
    t_download;
    close_out;
  end
endmodule : pmic_shutdown_lowpower_modes_tb_top
